// ### logic/nvmcfg_defs.vh
// Constants for the protect and device configuration register bank.
// Assumes inclusion by bare name from the design files only.
`ifndef NVMCFG_DEFS_VH
`define NVMCFG_DEFS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define NVMCFG_OFF_PROT_LO   8'h0c
`define NVMCFG_OFF_PROT_HI   8'h0d
`define NVMCFG_OFF_LOCAL_IF  8'h0e
`define NVMCFG_OFF_DEV_CFG   8'h12
`define NVMCFG_OFF_ERR_CLR   8'h14
`define NVMCFG_OFF_ERR_LOG   8'h34
`define NVMCFG_OFF_STATUS49  8'h31

// ****************************************************************
// Field positions
// ****************************************************************
`define NVMCFG_LIF_PULLUP    5
`define NVMCFG_CFG_PEC       7
`define NVMCFG_CFG_PARITY_CHECK_DISABLE   6
`define NVMCFG_CFG_PROTO     5
`define NVMCFG_CFG_DPTR_EN   4
`define NVMCFG_CFG_DPTR_HI   3
`define NVMCFG_CFG_DPTR_LO   2
`define NVMCFG_CFG_BURST     1
`define NVMCFG_ERR_PROT_WR   6

// ****************************************************************
// Masks, reset values and codes
// ****************************************************************
`define NVMCFG_LIF_WMASK     8'h20
`define NVMCFG_CFG_WMASK     8'hde
`define NVMCFG_RST_BYTE      8'h00
`define NVMCFG_DPTR_STATUS   2'h0
`define NVMCFG_BURST_SHORT   3'h2
`define NVMCFG_BURST_LONG    3'h4
`define NVMCFG_BITS_BYTE     4'h8

`endif

// ### logic/nvmcfg_link.v
// Host bus front end: synchronises clock and data pins, finds edges.
// Assumes both pins are asynchronous to sys_clk_i.
`timescale 1ns/100ps
`default_nettype none

module nvmcfg_link (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire scl_rise_o,
    output wire scl_fall_o,
    output wire start_o,
    output wire stop_o
);

// ****************************************************************
// Two-stage synchronisers plus one history stage
// ****************************************************************
reg scl_meta_reg;
reg scl_sync_reg;
reg scl_prev_reg;
reg sda_meta_reg;
reg sda_sync_reg;
reg sda_prev_reg;

// Meta stages feed only the sync stages
always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        scl_meta_reg <= 1'b1;
        scl_sync_reg <= 1'b1;
        scl_prev_reg <= 1'b1;
        sda_meta_reg <= 1'b1;
        sda_sync_reg <= 1'b1;
        sda_prev_reg <= 1'b1;
    end else begin
        scl_meta_reg <= scl_i;
        scl_sync_reg <= scl_meta_reg;
        scl_prev_reg <= scl_sync_reg;
        sda_meta_reg <= sda_i;
        sda_sync_reg <= sda_meta_reg;
        sda_prev_reg <= sda_sync_reg;
    end
end

// Edges; data change while clock stays high marks START or STOP
assign sda_o = sda_sync_reg;
assign scl_rise_o = scl_sync_reg & ~scl_prev_reg;
assign scl_fall_o = ~scl_sync_reg & scl_prev_reg;
assign start_o = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
assign stop_o = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

endmodule // nvmcfg_link

`default_nettype wire

// ### logic/nvmcfg_regs.v
// Protect and device configuration registers behind a two-wire target.
// Assumes CCC decode, bus reset and the memory engine sit outside and
// give one-cycle pulses on sys_clk_i; host pins come in asynchronously.
//
// Operation
// R01 - Register 0x0c holds protect bits for blocks 0 to 7, bit n.
// R02 - Register 0x0d holds protect bits for blocks 8 to 15.
// R03 - Protect bits once set stay set unless offline tester mode.
// R04 - Protect and local interface writes take effect after STOP.
// R05 - Register 0x0e bit 5 picks internal or external local pull-up.
// R06 - Host may rewrite the pull-up choice after power-up.
// R07 - Config bit 7 enables packet check, only under I3C Basic.
// R08 - Config bit 6 disables parity under I3C; T bit ignored.
// R09 - RSTDAA or bus reset restores packet check and parity bits.
// R10 - Read-only config bit 5 reports protocol: 0 two-wire, 1 I3C.
// R11 - SETAASA, RSTDAA or bus reset updates the protocol bit.
// R12 - Protocol bit is readable, normal writes never change it.
// R13 - New protocol applies from the START after the closing STOP.
// R14 - Config bit 4 enables default read pointer; else host pointer.
// R15 - Config bits 3:2 pick default start; 00 means status index 49.
// R16 - Config bit 1 sets checked burst: 0 two bytes, 1 four bytes.
// R17 - Protected block write sets error bit 6; writing clear clears.
// R18 - Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "nvmcfg_defs.vh"

module nvmcfg_regs #(
    parameter [6:0] DEV_ADDR = 7'h50
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire scl_i,
    input wire sda_i,
    input wire offline_test_i,
    input wire ccc_setaasa_i,
    input wire ccc_rstdaa_i,
    input wire bus_reset_i,
    input wire prot_write_err_i,
    output reg sda_o,
    output reg sda_oe_o,
    output wire [15:0] block_protect_o,
    output wire pullup_ext_o,
    output wire host_protocol_o,
    output reg packet_check_o,
    output reg parity_ignore_o,
    output reg default_ptr_en_o,
    output reg [2:0] check_burst_o,
    output wire prot_write_err_o
);

// ****************************************************************
// Link front end
// ****************************************************************
wire sda_s;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;

nvmcfg_link u_link (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(bus_start),
    .stop_o(bus_stop)
);

// Offline tester strap comes from a pin
reg offl_meta_reg;
reg offl_sync_reg;

always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        offl_meta_reg <= 1'b0;
        offl_sync_reg <= 1'b0;
    end else begin
        offl_meta_reg <= offline_test_i;
        offl_sync_reg <= offl_meta_reg;
    end
end

// ****************************************************************
// Register state
// ****************************************************************
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_PTR = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_RD = 3'h4;

reg [2:0] state_reg;
reg [3:0] bit_cnt_reg;
reg ack_phase_reg;
reg [7:0] shift_reg;
reg [7:0] tx_reg;
reg [7:0] ptr_reg;
reg ptr_set_reg;
reg [7:0] prot_lo_reg;
reg [7:0] prot_hi_reg;
reg [7:0] lif_reg;
reg [7:0] cfg_reg;
reg [7:0] prot_lo_stage_reg;
reg [7:0] prot_hi_stage_reg;
reg [7:0] lif_stage_reg;
reg [7:0] cfg_stage_reg;
reg proto_sel_reg;
reg proto_act_reg;
reg err_clr_reg;
reg err_reg;

assign block_protect_o = {prot_hi_reg, prot_lo_reg}; // R01 R02
assign pullup_ext_o = lif_reg[`NVMCFG_LIF_PULLUP]; // R05
assign host_protocol_o = proto_act_reg;
assign prot_write_err_o = err_reg;

// Read view; bit 5 shows the latest protocol, zero where reserved
reg [7:0] rd_data;
always @* begin
    case (ptr_reg)
        `NVMCFG_OFF_PROT_LO: rd_data = prot_lo_reg;
        `NVMCFG_OFF_PROT_HI: rd_data = prot_hi_reg;
        `NVMCFG_OFF_LOCAL_IF: rd_data = lif_reg; // R18
        `NVMCFG_OFF_DEV_CFG: rd_data = (cfg_reg & `NVMCFG_CFG_WMASK) |
            ({7'h00, proto_sel_reg} << `NVMCFG_CFG_PROTO); // R10 R12
        `NVMCFG_OFF_ERR_LOG: rd_data = {7'h00, err_reg} << `NVMCFG_ERR_PROT_WR;
        default: rd_data = `NVMCFG_RST_BYTE;
    endcase
end

// Default pointer only used when enabled and start code is 00
wire dptr_use = cfg_reg[`NVMCFG_CFG_DPTR_EN] &
    (cfg_reg[`NVMCFG_CFG_DPTR_HI:`NVMCFG_CFG_DPTR_LO] == `NVMCFG_DPTR_STATUS);

// ****************************************************************
// Target engine and staged updates
// ****************************************************************
// Writes other than error clear land in stage copies; the live copies follow only at STOP so a
// half-finished transfer can never disturb protection mid-flight.
always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        state_reg <= ST_IDLE;
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b0;
        shift_reg <= 8'h00;
        tx_reg <= 8'h00;
        ptr_reg <= 8'h00;
        ptr_set_reg <= 1'b0;
        prot_lo_reg <= `NVMCFG_RST_BYTE;
        prot_hi_reg <= `NVMCFG_RST_BYTE;
        lif_reg <= `NVMCFG_RST_BYTE;
        cfg_reg <= `NVMCFG_RST_BYTE;
        prot_lo_stage_reg <= `NVMCFG_RST_BYTE;
        prot_hi_stage_reg <= `NVMCFG_RST_BYTE;
        lif_stage_reg <= `NVMCFG_RST_BYTE;
        cfg_stage_reg <= `NVMCFG_RST_BYTE;
        proto_sel_reg <= 1'b0;
        proto_act_reg <= 1'b0;
        err_clr_reg <= 1'b0;
        sda_o <= 1'b0;
        sda_oe_o <= 1'b0;
    end else begin
        err_clr_reg <= 1'b0;
        if (bus_start) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_oe_o <= 1'b0;
            proto_act_reg <= proto_sel_reg; // R13
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            ack_phase_reg <= 1'b0;
            ptr_set_reg <= 1'b0;
            sda_oe_o <= 1'b0;
            prot_lo_reg <= prot_lo_stage_reg; // R04
            prot_hi_reg <= prot_hi_stage_reg; // R04
            lif_reg <= lif_stage_reg; // R04
            cfg_reg <= cfg_stage_reg;
        end else if (scl_rise && state_reg != ST_IDLE) begin
            if (ack_phase_reg) begin
                // Host NACK ends a read burst
                if (state_reg == ST_RD && sda_s)
                    state_reg <= ST_IDLE;
            end else begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end else if (scl_fall && state_reg != ST_IDLE) begin
            if (ack_phase_reg) begin
                ack_phase_reg <= 1'b0;
                if (state_reg == ST_RD) begin
                    tx_reg <= {rd_data[6:0], 1'b0};
                    sda_oe_o <= ~rd_data[7];
                    ptr_reg <= ptr_reg + 8'h01;
                end else begin
                    sda_oe_o <= 1'b0;
                end
            end else if (bit_cnt_reg == `NVMCFG_BITS_BYTE) begin
                bit_cnt_reg <= 4'h0;
                ack_phase_reg <= 1'b1;
                case (state_reg)
                    ST_ADDR: begin
                        if (shift_reg[7:1] == DEV_ADDR) begin
                            sda_oe_o <= 1'b1;
                            if (shift_reg[0]) begin
                                state_reg <= ST_RD;
                                if (!ptr_set_reg && dptr_use) // R14 R15
                                    ptr_reg <= `NVMCFG_OFF_STATUS49;
                            end else begin
                                state_reg <= ST_PTR;
                            end
                        end else begin
                            state_reg <= ST_IDLE;
                            ack_phase_reg <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        sda_oe_o <= 1'b1;
                        ptr_reg <= shift_reg;
                        ptr_set_reg <= 1'b1;
                        state_reg <= ST_WR;
                    end
                    ST_WR: begin
                        sda_oe_o <= 1'b1;
                        ptr_reg <= ptr_reg + 8'h01;
                        case (ptr_reg)
                            `NVMCFG_OFF_PROT_LO: prot_lo_stage_reg <=
                                offl_sync_reg ? shift_reg :
                                (prot_lo_stage_reg | shift_reg); // R03
                            `NVMCFG_OFF_PROT_HI: prot_hi_stage_reg <=
                                offl_sync_reg ? shift_reg :
                                (prot_hi_stage_reg | shift_reg); // R03
                            `NVMCFG_OFF_LOCAL_IF: lif_stage_reg <=
                                shift_reg & `NVMCFG_LIF_WMASK; // R06 R18
                            `NVMCFG_OFF_DEV_CFG: cfg_stage_reg <=
                                shift_reg & `NVMCFG_CFG_WMASK; // R12 R18
                            `NVMCFG_OFF_ERR_CLR: err_clr_reg <=
                                shift_reg[`NVMCFG_ERR_PROT_WR]; // R17
                            default: err_clr_reg <= 1'b0;
                        endcase
                    end
                    ST_RD: begin
                        sda_oe_o <= 1'b0; // Host owns the ack slot
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end else if (state_reg == ST_RD) begin
                sda_oe_o <= ~tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
        // Bus events outrank same-cycle register updates
        if (ccc_setaasa_i)
            proto_sel_reg <= 1'b1; // R11
        if (ccc_rstdaa_i || bus_reset_i) begin
            proto_sel_reg <= 1'b0; // R11
            cfg_reg[`NVMCFG_CFG_PEC] <= 1'b0; // R09
            cfg_reg[`NVMCFG_CFG_PARITY_CHECK_DISABLE] <= 1'b0; // R09
            cfg_stage_reg[`NVMCFG_CFG_PEC] <= 1'b0; // R09
            cfg_stage_reg[`NVMCFG_CFG_PARITY_CHECK_DISABLE] <= 1'b0; // R09
        end
    end
end

// ****************************************************************
// Error flag
// ****************************************************************
// A violation in the clear cycle keeps the flag set
always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
        err_reg <= 1'b0;
    else if (prot_write_err_i)
        err_reg <= 1'b1; // R17
    else if (err_clr_reg)
        err_reg <= 1'b0; // R17
end

// ****************************************************************
// Derived controls
// ****************************************************************
// Registered so every output leaves from a flip-flop
always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
        packet_check_o <= 1'b0;
        parity_ignore_o <= 1'b0;
        default_ptr_en_o <= 1'b0;
        check_burst_o <= 3'h0;
    end else begin
        packet_check_o <= cfg_reg[`NVMCFG_CFG_PEC] & proto_act_reg; // R07
        parity_ignore_o <= cfg_reg[`NVMCFG_CFG_PARITY_CHECK_DISABLE] & proto_act_reg; // R08
        default_ptr_en_o <= dptr_use; // R14
        if (cfg_reg[`NVMCFG_CFG_PEC] && cfg_reg[`NVMCFG_CFG_DPTR_EN] &&
                proto_act_reg)
            check_burst_o <= cfg_reg[`NVMCFG_CFG_BURST] ?
                `NVMCFG_BURST_LONG : `NVMCFG_BURST_SHORT; // R16
        else
            check_burst_o <= 3'h0;
    end
end

endmodule // nvmcfg_regs

`default_nettype wire

// ### test/nvmcfg_regs_props.sv
// Checker for the protect and configuration register bank.
// Assumes it is bound to nvmcfg_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module nvmcfg_regs_props (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic offline_test_i,
    input wire logic ccc_rstdaa_i,
    input wire logic bus_reset_i,
    input wire logic prot_write_err_i,
    input wire logic sda_oe_o,
    input wire logic [15:0] block_protect_o,
    input wire logic pullup_ext_o,
    input wire logic host_protocol_o,
    input wire logic packet_check_o,
    input wire logic parity_ignore_o,
    input wire logic [2:0] check_burst_o,
    input wire logic prot_write_err_o
);
    // ****************************************************************
    // Port relations
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    // Live settings move only once the bus is idle after a STOP
    a_live_after_stop: assert property ($changed({block_protect_o,
        pullup_ext_o}) |-> scl_i && sda_i) else $error("live change mid frame");
    a_protect_sticky: assert property (
        (|($past(block_protect_o) & ~block_protect_o)) |->
        $past(offline_test_i, 5)) else $error("protect bit cleared");
    a_proto_at_start: assert property ($changed(host_protocol_o)
        |-> !sda_i) else $error("protocol changed outside a START");
    a_pec_gated: assert property (packet_check_o
        |-> $past(host_protocol_o)) else $error("packet check in two-wire");
    a_parity_gated: assert property (parity_ignore_o
        |-> $past(host_protocol_o)) else $error("parity ignored in two-wire");
    a_burst_codes: assert property (check_burst_o != 3'h0 |->
        (check_burst_o == 3'h2 || check_burst_o == 3'h4) && packet_check_o)
        else $error("bad checked burst");
    a_reset_ccc: assert property ((ccc_rstdaa_i || bus_reset_i) |->
        ##[1:3] (!packet_check_o && !parity_ignore_o))
        else $error("packet or parity setting survived reset event");
    a_err_set: assert property (prot_write_err_i |=>
        prot_write_err_o) else $error("error flag not set");
    a_err_clear: assert property ($fell(prot_write_err_o) |->
        !scl_i && !$past(prot_write_err_i)) else $error("error flag lost");
    // Data pin may only move while the bus clock is low
    a_sda_low_clk: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data moved with clock high");
endmodule // nvmcfg_regs_props

bind nvmcfg_regs nvmcfg_regs_props u_props (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
    .offline_test_i(offline_test_i), .ccc_rstdaa_i(ccc_rstdaa_i),
    .bus_reset_i(bus_reset_i), .prot_write_err_i(prot_write_err_i),
    .sda_oe_o(sda_oe_o), .block_protect_o(block_protect_o),
    .pullup_ext_o(pullup_ext_o), .host_protocol_o(host_protocol_o),
    .packet_check_o(packet_check_o), .parity_ignore_o(parity_ignore_o),
    .check_burst_o(check_burst_o), .prot_write_err_o(prot_write_err_o)
);
`default_nettype wire

// ### test/nvmcfg_host.sv
// Host controller model for the two-wire host bus.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module nvmcfg_host (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // ****************************************************************
    // Bus cycles, 10 system cycles per bus clock
    // ****************************************************************
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Released data first, so a target ack from the last bit has gone
    task automatic start();
        wt(2);
        sda_oe_o <= 1'b0;
        wt(3);
        scl_o <= 1'b1;
        wt(5);
        sda_oe_o <= 1'b1;
        wt(5);
        scl_o <= 1'b0;
    endtask

    task automatic stop();
        wt(2);
        sda_oe_o <= 1'b1;
        wt(3);
        scl_o <= 1'b1;
        wt(5);
        sda_oe_o <= 1'b0;
        wt(10);
    endtask

    // Data set mid-low, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        wt(2);
        sda_oe_o <= ~b;
        wt(3);
        scl_o <= 1'b1;
        wt(3);
        r = sda_i;
        wt(2);
        scl_o <= 1'b0;
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Last set means a NACK that ends the read burst
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule // nvmcfg_host
`default_nettype wire

// ### test/test_nvmcfg_regs.sv
// Self-checking bench for the protect and configuration register bank.
// Assumes nvmcfg_host drives the bus and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none

module test_nvmcfg_regs;
    logic sys_clk_i, rstn_i, offline_test_i;
    logic [3:0] ev;
    wire scl, sda, h_oe, sda_o, sda_oe_o, pullup_ext_o, host_protocol_o;
    wire packet_check_o, parity_ignore_o, default_ptr_en_o, prot_write_err_o;
    wire setaasa, rstdaa, bus_rst, perr;
    wire [15:0] block_protect_o;
    wire [2:0] check_burst_o;
    int n_errors, comparisons;
    logic [7:0] regs [4] = '{8'h0c, 8'h0d, 8'h0e, 8'h12};

    // Open-drain data wire with board pull-up
    assign sda = ~(h_oe | sda_oe_o);
    assign {perr, bus_rst, rstdaa, setaasa} = ev;

    nvmcfg_host host (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl),
        .sda_oe_o(h_oe));
    nvmcfg_regs dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl),
        .sda_i(sda), .offline_test_i(offline_test_i), .ccc_setaasa_i(setaasa),
        .ccc_rstdaa_i(rstdaa), .bus_reset_i(bus_rst), .prot_write_err_i(perr),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .block_protect_o(block_protect_o),
        .pullup_ext_o(pullup_ext_o), .host_protocol_o(host_protocol_o),
        .packet_check_o(packet_check_o), .parity_ignore_o(parity_ignore_o),
        .default_ptr_en_o(default_ptr_en_o), .check_burst_o(check_burst_o),
        .prot_write_err_o(prot_write_err_o));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Live settings must not move before the closing STOP
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic a;
        logic [16:0] live;
        live = {block_protect_o, pullup_ext_o};
        host.start();
        host.put(8'ha0, a);
        check(a, 1'b1);
        host.put(p, a);
        host.put(d, a);
        check({block_protect_o, pullup_ext_o}, live);
        host.stop();
    endtask

    // Pointer write, repeated START, one byte read with NACK
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        host.start();
        host.put(8'ha0, a);
        host.put(p, a);
        host.start();
        host.put(8'ha1, a);
        host.get(1'b1, d);
        host.stop();
        check(d, exp);
    endtask

    // Read at the current pointer, no pointer byte since the last STOP
    task automatic rdc(input logic [7:0] exp);
        logic a;
        logic [7:0] d;
        host.start();
        host.put(8'ha1, a);
        host.get(1'b1, d);
        host.stop();
        check(d, exp);
    endtask

    task automatic pulse(input logic [3:0] m);
        ev <= m;
        @(posedge sys_clk_i);
        ev <= 4'h0;
        repeat (2) @(posedge sys_clk_i);
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic a;
        ev = 4'h0;
        offline_test_i = 1'b0;
        rstn_i = 1'b0;
        repeat (12) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        foreach (regs[i]) rd(regs[i], 8'h00);
        host.start();
        host.put(8'ha2, a);
        check(a, 1'b0); // Foreign address is not acked
        check(sda_o, 1'b0); // Open drain only ever pulls low
        host.stop();
        wr(8'h0c, 8'h81);
        wr(8'h0d, 8'hff);
        check(block_protect_o, 16'hff81);
        rd(8'h0d, 8'hff);
        wr(8'h0c, 8'h00);
        check(block_protect_o, 16'hff81);
        offline_test_i <= 1'b1;
        wr(8'h0c, 8'h00);
        wr(8'h0d, 8'h00);
        repeat (8) @(posedge sys_clk_i);
        offline_test_i <= 1'b0;
        check(block_protect_o, 16'h0000);
        wr(8'h0e, 8'hff);
        check(pullup_ext_o, 1'b1);
        rd(8'h0e, 8'h20);
        wr(8'h0e, 8'h00);
        check(pullup_ext_o, 1'b0);
        wr(8'h12, 8'hff);
        rd(8'h12, 8'hde);
        // Pointer left at 0x12; reserved start code keeps host pointer
        rd(8'h11, 8'h00);
        rdc(8'hde);
        check({default_ptr_en_o, packet_check_o}, 2'b00);
        wr(8'h12, 8'hd2);
        check({default_ptr_en_o, packet_check_o}, 2'b10);
        // Host pointer would give 0xd2; default pointer reads status 0x31
        rd(8'h11, 8'h00);
        rdc(8'h00);
        pulse(4'h1);
        check(host_protocol_o, 1'b0);
        rd(8'h12, 8'hf2);
        check(host_protocol_o, 1'b1);
        check({packet_check_o, parity_ignore_o}, 2'b11);
        check(check_burst_o, 3'h4);
        wr(8'h12, 8'hd0);
        check(check_burst_o, 3'h2);
        // Each reset event in turn, from I3C with checks enabled
        for (int k = 0; k < 2; k++) begin
            pulse(4'h1);
            wr(8'h12, 8'hd0);
            rd(8'h12, 8'hf0);
            pulse(k == 0 ? 4'h4 : 4'h2);
            rd(8'h12, 8'h10);
            check({host_protocol_o, packet_check_o}, 2'b00);
        end
        pulse(4'h8);
        check(prot_write_err_o, 1'b1);
        rd(8'h34, 8'h40);
        wr(8'h14, 8'h40);
        check(prot_write_err_o, 1'b0);
        wr(8'h20, 8'h55);
        rd(8'h20, 8'h00);
        give_verdict();
    end

    // Tests need about 11400 cycles
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        n_errors++;
        give_verdict();
    end
endmodule // test_nvmcfg_regs
`default_nettype wire
